// *** rtl/ciw_ctrl.sv ***
// Mode control, wake-up, interrupt flags and bus-off recovery.
// Assumes the protocol engine gives one bit_tick per bit time and
// one-cycle event pulses on sys_clk; clear strobes are write-one pulses.
`include "ciw_regs.svh"
`timescale 1ns/1ps
module ciw_ctrl #(
   parameter int FILT_LEN = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic bus_receive_input,
   input wire logic engine_tx,
   output logic bus_transmit_output,
   output logic rx_internal,
   input wire logic controller_on_bit,
   input wire logic init_request,
   input wire logic sleep_request,
   input wire logic wake_on_activity_enable,
   input wire logic wake_glitch_filter_select,
   input wire logic busoff_recovery_select,
   input wire logic busoff_hold_clear,
   input wire logic bus_idle,
   input wire logic bit_tick,
   input wire logic rx_msg_done,
   input wire logic rx_fifo_pending,
   input wire logic rx_overrun,
   input wire logic [2:0] tx_sent,
   input wire logic [1:0] err_tx_state,
   input wire logic [1:0] err_rx_state,
   input wire logic busoff_entry,
   input wire logic clr_wake,
   input wire logic clr_status_change,
   input wire logic clr_overrun,
   input wire logic clr_receive_full,
   input wire logic [2:0] clr_tx_empty,
   input wire logic wake_int_enable,
   input wire logic status_change_int_enable,
   input wire logic overrun_int_enable,
   input wire logic receive_full_int_enable,
   input wire logic [2:0] tx_empty_int_enables,
   output ciw_pkg::ciw_mode_t mode_state,
   output logic init_ack,
   output logic sleep_ack,
   output logic module_clk_run,
   output logic bus_synced,
   output logic rx_fg_load,
   output logic busoff_state,
   output logic busoff_hold,
   output logic wake_int_flag,
   output logic status_change_flag,
   output logic overrun_flag,
   output logic receive_full_flag,
   output logic [2:0] tx_buffer_empty_flags,
   output logic [1:0] tx_state_field,
   output logic [1:0] rx_state_field,
   output logic irq_wake,
   output logic irq_error,
   output logic irq_receive,
   output logic irq_transmit
);
   import ciw_pkg::*;

   ciw_mode_t mode_ff; // Current mode
   ciw_mode_t nxt_mode;
   logic rx_sync; // Synchronised receive line
   logic wake_pulse; // Bus activity seen while armed
   logic wake_evt; // Activity that ends sleep
   logic resync_ff; // Waiting for idle run after wake
   logic [3:0] run_cnt_ff; // Consecutive recessive bits
   logic run_done; // One full idle sequence seen
   logic [7:0] seq_cnt_ff; // Idle sequences while bus-off
   logic seq_done;
   logic busoff_ff; // Bus-off state
   logic hold_ff; // User hold on bus-off exit
   logic recover; // Leave bus-off this cycle
   logic wake_ff, csc_ff, ovr_ff, rxf_ff;
   logic [2:0] txe_ff;
   logic [1:0] tst_ff, rst_ff; // Reported error states
   logic state_chg; // Error counters moved into a critical range
   logic in_sleep;

   // Detector only armed in sleep with wake enabled
   ciw_wake_det #(
      .FILT_LEN(FILT_LEN),
      .FILT_W(4)
   ) u_wake (
      .sys_clk(sys_clk),
      .rst(rst),
      .bus_receive_input(bus_receive_input),
      .filter_en(wake_glitch_filter_select),
      .armed(in_sleep && wake_on_activity_enable),
      .rx_sync(rx_sync),
      .wake_pulse(wake_pulse)
   );

   assign in_sleep = (mode_ff == ciw_sleep);
   assign wake_evt = wake_pulse && wake_on_activity_enable;
   assign mode_state = mode_ff;
   assign init_ack = (mode_ff == ciw_init);
   assign sleep_ack = in_sleep;
   // Clocks stop when disabled or asleep; registers stay reachable
   assign module_clk_run = (mode_ff == ciw_init) || (mode_ff == ciw_run);
   // Masking the line in sleep with wake disabled hides bus activity; only init, a dropped sleep request or clearing controller_on_bit ends sleep
   assign rx_internal = (in_sleep && !wake_on_activity_enable) ? 1'b1 :
                        rx_sync;
   assign bus_transmit_output = (mode_ff == ciw_run && !resync_ff) ?
                                engine_tx : 1'b1; // recessive until rejoined
   assign bus_synced = !resync_ff;

   // Mode sequencing; a sleep request waits for idle bus and no pending tx
   always_comb
   begin
      nxt_mode = mode_ff;
      case (mode_ff)
         ciw_off:
            if (controller_on_bit)
               nxt_mode = init_request ? ciw_init : ciw_run;
         ciw_init:
            if (!init_request)
               nxt_mode = ciw_run;
         ciw_run:
            if (init_request)
               nxt_mode = ciw_init;
            else if (sleep_request && bus_idle && (&txe_ff))
               nxt_mode = ciw_sleep;
         ciw_sleep:
            if (init_request)
               nxt_mode = ciw_init;
            else if (wake_evt || !sleep_request)
               nxt_mode = ciw_run;
         default:
            nxt_mode = ciw_off;
      endcase
      if (!controller_on_bit)
         nxt_mode = ciw_off;
   end

   // Mode register
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         mode_ff <= ciw_off;
      else
         mode_ff <= nxt_mode;
   end

   // Consecutive recessive bit counter on the internal receive level
   assign run_done = bit_tick && rx_internal &&
                     (run_cnt_ff == `CIW_RECESSIVE_RUN - 4'h1);
   always_ff @(posedge sys_clk)
   begin
      if (rst || in_sleep)
         run_cnt_ff <= 4'h0;
      else if (bit_tick)
      begin
         if (!rx_internal || run_done)
            run_cnt_ff <= 4'h0;
         else
            run_cnt_ff <= run_cnt_ff + 4'h1;
      end
   end

   // After leaving sleep for run, stay off the bus until one idle run is seen
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         resync_ff <= 1'b0;
      else if (in_sleep && nxt_mode == ciw_run)
         resync_ff <= 1'b1;
      else if (run_done)
         resync_ff <= 1'b0;
   end

   // Bus-off sequence counter; frozen while asleep
   assign seq_done = (seq_cnt_ff == `CIW_BUSOFF_SEQS);
   always_ff @(posedge sys_clk)
   begin
      if (rst || !busoff_ff)
         seq_cnt_ff <= 8'h00;
      else if (run_done && !in_sleep && !seq_done)
         seq_cnt_ff <= seq_cnt_ff + 8'h01;
   end

   // Recovery: automatic, or also gated by the user hold in either order
   assign recover = busoff_ff && seq_done &&
                    (!busoff_recovery_select || !hold_ff);
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         busoff_ff <= 1'b0;
      else if (busoff_entry)
         busoff_ff <= 1'b1;
      else if (recover)
         busoff_ff <= 1'b0;
   end

   // Hold is armed on entry in user mode and cleared by software
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         hold_ff <= 1'b0;
      else if (busoff_entry && busoff_recovery_select)
         hold_ff <= 1'b1;
      else if (busoff_hold_clear)
         hold_ff <= 1'b0;
   end
   assign busoff_state = busoff_ff;
   assign busoff_hold = hold_ff;

   // Foreground load: a new frame, or a queued one once the slot is free;
   // no shifting into the foreground while asleep
   assign rx_fg_load = !in_sleep &&
                       (rx_msg_done || (rx_fifo_pending && !rxf_ff));

   // Error range entry is any change to a non-normal state code
   assign state_chg = ((err_tx_state != tst_ff) ||
                       (err_rx_state != rst_ff)) &&
                      ((err_tx_state != `CIW_STATE_OK) ||
                       (err_rx_state != `CIW_STATE_OK));

   // State fields follow the counters so software sees the newest range
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         tst_ff <= `CIW_STATE_OK;
         rst_ff <= `CIW_STATE_OK;
      end
      else
      begin
         tst_ff <= err_tx_state;
         rst_ff <= err_rx_state;
      end
   end

   // Sticky flags: a set in the clear cycle wins, so a clear is void
   // while its condition still holds
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wake_ff <= 1'b0;
         csc_ff <= 1'b0;
         ovr_ff <= 1'b0;
         rxf_ff <= 1'b0;
      end
      else
      begin
         wake_ff <= (in_sleep && wake_evt) || (wake_ff && !clr_wake);
         csc_ff <= state_chg || (csc_ff && !clr_status_change);
         ovr_ff <= rx_overrun || (ovr_ff && !clr_overrun);
         rxf_ff <= rx_fg_load || (rxf_ff && !clr_receive_full);
      end
   end

   // Transmit empty flags, one per buffer; write-one schedules it
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         txe_ff <= `CIW_TXE_RST;
      else
         txe_ff <= tx_sent | (txe_ff & ~clr_tx_empty);
   end

   assign wake_int_flag = wake_ff;
   assign status_change_flag = csc_ff;
   assign overrun_flag = ovr_ff;
   assign receive_full_flag = rxf_ff;
   assign tx_buffer_empty_flags = txe_ff;
   assign tx_state_field = tst_ff;
   assign rx_state_field = rst_ff;

   // Request lines are levels that hold while any enabled flag is set
   assign irq_wake = wake_ff && wake_int_enable;
   assign irq_error = (csc_ff && status_change_int_enable) ||
                      (ovr_ff && overrun_int_enable);
   assign irq_receive = rxf_ff && receive_full_int_enable;
   assign irq_transmit = |(txe_ff & tx_empty_int_enables);

   sequence s_wake_exit;
      in_sleep && wake_evt && !init_request && controller_on_bit;
   endsequence
   sequence s_resync;
      !bus_synced && (mode_ff == ciw_run);
   endsequence

   chk_disable_off: assert property (@(posedge sys_clk)
      disable iff (rst) !controller_on_bit |=> mode_ff == ciw_off &&
      !module_clk_run) else $error("not disabled when controller off");
   chk_wake_leaves: assert property (@(posedge sys_clk)
      disable iff (rst) s_wake_exit |=> s_resync)
      else $error("wake did not leave sleep into resync");
   chk_wake_gate: assert property (@(posedge sys_clk)
      disable iff (rst) $rose(wake_int_flag) |-> $past(in_sleep) &&
      $past(wake_on_activity_enable))
      else $error("wake flag set outside armed sleep");
   chk_set_wins: assert property (@(posedge sys_clk)
      disable iff (rst) rx_fg_load && clr_receive_full |=> receive_full_flag)
      else $error("receive-full lost to a clear");
   chk_err_line: assert property (@(posedge sys_clk)
      disable iff (rst) overrun_flag && overrun_int_enable |-> irq_error)
      else $error("error line low with overrun pending");
   // A sent buffer must show empty next cycle, even against a clear
   chk_tx_empty_set: assert property (@(posedge sys_clk)
      disable iff (rst) |tx_sent |=>
      (tx_buffer_empty_flags & $past(tx_sent)) == $past(tx_sent))
      else $error("sent buffer not flagged empty");
   chk_seq_pause: assert property (@(posedge sys_clk)
      disable iff (rst) in_sleep && busoff_ff && $past(in_sleep) |->
      $stable(seq_cnt_ff)) else $error("bus-off count moved in sleep");
   chk_auto_exit: assert property (@(posedge sys_clk)
      disable iff (rst) busoff_ff && seq_done && !busoff_recovery_select
      && !busoff_entry |=> !busoff_state)
      else $error("automatic bus-off exit missing");
   chk_hold_keeps: assert property (@(posedge sys_clk)
      disable iff (rst) busoff_ff && hold_ff && busoff_recovery_select |=>
      busoff_state) else $error("bus-off left while hold set");
   chk_rx_masked: assert property (@(posedge sys_clk)
      disable iff (rst) in_sleep && !wake_on_activity_enable |-> rx_internal)
      else $error("receive not held recessive in sleep");
   chk_csc_fields: assert property (@(posedge sys_clk)
      disable iff (rst) state_chg |=> status_change_flag &&
      tx_state_field == $past(err_tx_state))
      else $error("status change not recorded");
endmodule

// *** rtl/ciw_regs.svh ***
// Counts and reset values for the wake, interrupt and bus-off block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef CIW_REGS_SVH
`define CIW_REGS_SVH

// Consecutive recessive bits that form one idle sequence
`define CIW_RECESSIVE_RUN 4'hb
// Idle sequences needed before bus-off may be left
`define CIW_BUSOFF_SEQS 8'h80
// Transmit buffers are empty out of reset
`define CIW_TXE_RST 3'h7
// Error state field code for the normal, error-free range
`define CIW_STATE_OK 2'h0

`endif

// *** rtl/ciw_pkg.sv ***
// Types shared by the wake, interrupt and bus-off block.
// Assumes nothing of its surroundings.
package ciw_pkg;
   // Operating mode of the controller
   typedef enum logic [1:0] {
      ciw_off,
      ciw_init,
      ciw_run,
      ciw_sleep
   } ciw_mode_t;
endpackage

// *** rtl/ciw_wake_det.sv ***
// Receive pin synchroniser and bus-activity detector with glitch filter.
// Assumes the pin is asynchronous to sys_clk and idles recessive (high).
`timescale 1ns/1ps
module ciw_wake_det #(
   parameter int FILT_LEN = 8,
   parameter int FILT_W = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic bus_receive_input,
   input wire logic filter_en,
   input wire logic armed,
   output logic rx_sync,
   output logic wake_pulse
);
   logic meta_ff; // First stage, read by the second stage only
   logic sync_ff; // Synchronised line level
   logic prev_ff; // Previous synchronised level for edge detection
   logic [FILT_W-1:0] low_cnt_ff; // Consecutive dominant samples
   logic wake_ff; // Registered wake pulse
   logic nxt_wake;

   assign rx_sync = sync_ff;
   assign wake_pulse = wake_ff;

   // Two-stage synchroniser; runs off the register clock so that it
   // keeps watching the line while the protocol clocks are stopped
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
         prev_ff <= 1'b1;
      end
      else
      begin
         meta_ff <= bus_receive_input;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // Low-pass filter: count dominant samples, restart on recessive
   always_ff @(posedge sys_clk)
   begin
      if (rst || sync_ff)
         low_cnt_ff <= '0;
      else if (low_cnt_ff != FILT_W'(FILT_LEN - 1))
         low_cnt_ff <= low_cnt_ff + 1'b1;
   end

   // Falling edge wakes directly; filtered mode needs a long dominant
   always_comb
   begin
      if (!armed)
         nxt_wake = 1'b0;
      else if (filter_en)
         nxt_wake = !sync_ff && (low_cnt_ff == FILT_W'(FILT_LEN - 2));
      else
         nxt_wake = prev_ff && !sync_ff;
   end

   // Register the wake event
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         wake_ff <= 1'b0;
      else
         wake_ff <= nxt_wake;
   end
endmodule

// *** verification/ciw_bus_model.sv ***
// Far side of the block: the CAN bus pin and the engine's bit timing.
// Assumes sys_clk is the register clock; one bit time is TICK_DIV cycles.
`timescale 1ns/1ps
module ciw_bus_model #(
   parameter int TICK_DIV = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic dom_req,
   output logic bus_receive_input,
   output logic bit_tick
);
   // Bit-time divider; small so the 128 idle runs fit a short run
   logic [7:0] div_ff;
   // Divider wraps every bit time
   always_ff @(posedge sys_clk)
   begin
      if (rst || div_ff == 8'(TICK_DIV - 1))
         div_ff <= 8'h00;
      else
         div_ff <= div_ff + 8'h01;
   end
   // One tick per bit time, as the engine's bit clock gives it
   assign bit_tick = (div_ff == 8'h00);
   // Bus pulled recessive (high) unless another node drives dominant
   assign bus_receive_input = ~dom_req;
endmodule

// *** verification/can_interrupt_wake_busoff_bench.sv ***
// Bench for the wake, interrupt and bus-off block: pin-level stimulus
// and expected flags. Assumes ciw_pkg and the bus model compiled first.
`timescale 1ns/1ps
module can_interrupt_wake_busoff_bench;
   import ciw_pkg::*;
   // Host and engine side stimulus
   logic sys_clk, rst, engine_tx, controller_on_bit, init_request;
   logic sleep_request, wake_on_activity_enable, wake_glitch_filter_select;
   logic busoff_recovery_select, busoff_hold_clear, bus_idle, rx_msg_done;
   logic rx_fifo_pending, rx_overrun, busoff_entry, clr_wake;
   logic clr_status_change, clr_overrun, clr_receive_full, wake_int_enable;
   logic status_change_int_enable, overrun_int_enable, dom_req;
   logic receive_full_int_enable, bus_receive_input, bit_tick;
   logic [2:0] tx_sent, clr_tx_empty, tx_empty_int_enables;
   logic [1:0] err_tx_state, err_rx_state;
   // Observed outputs
   ciw_mode_t mode_state;
   logic bus_transmit_output, rx_internal, init_ack, sleep_ack;
   logic module_clk_run, bus_synced, rx_fg_load, busoff_state, busoff_hold;
   logic wake_int_flag, status_change_flag, overrun_flag, receive_full_flag;
   logic [2:0] tx_buffer_empty_flags;
   logic [1:0] tx_state_field, rx_state_field;
   logic irq_wake, irq_error, irq_receive, irq_transmit;
   int fail_count = 0;
   int checks_done = 0;
   int n;
   // Short filter keeps the glitch case quick
   ciw_ctrl #(.FILT_LEN(3)) dut_u (.sys_clk, .rst, .bus_receive_input,
      .engine_tx, .bus_transmit_output, .rx_internal, .controller_on_bit,
      .init_request, .sleep_request, .wake_on_activity_enable,
      .wake_glitch_filter_select, .busoff_recovery_select,
      .busoff_hold_clear, .bus_idle, .bit_tick, .rx_msg_done,
      .rx_fifo_pending, .rx_overrun, .tx_sent, .err_tx_state,
      .err_rx_state, .busoff_entry, .clr_wake, .clr_status_change,
      .clr_overrun, .clr_receive_full, .clr_tx_empty, .wake_int_enable,
      .status_change_int_enable, .overrun_int_enable,
      .receive_full_int_enable, .tx_empty_int_enables, .mode_state,
      .init_ack, .sleep_ack, .module_clk_run, .bus_synced, .rx_fg_load,
      .busoff_state, .busoff_hold, .wake_int_flag, .status_change_flag,
      .overrun_flag, .receive_full_flag, .tx_buffer_empty_flags,
      .tx_state_field, .rx_state_field, .irq_wake, .irq_error,
      .irq_receive, .irq_transmit);
   // Bus and bit timing
   ciw_bus_model #(.TICK_DIV(4)) bus_u (.sys_clk, .rst, .dom_req,
      .bus_receive_input, .bit_tick);
   // 50 ns clock
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [2:0] e,
      input logic [2:0] g);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Closing report
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // A wait that ran out of bound ends the run
   task automatic lim(input int cnt, input int mx);
      if (cnt >= mx)
      begin
         fail_count++;
         $display("mismatch wait expected done seen timeout");
         stop_test();
      end
   endtask
   // Edge helpers: drive after posedge, look at negedge
   task automatic pe(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic ne();
      @(negedge sys_clk);
   endtask
   // Main sequence
   initial
   begin
      rst = 1'b1;
      {engine_tx, controller_on_bit, init_request, sleep_request} = '0;
      {wake_on_activity_enable, wake_glitch_filter_select} = '0;
      {busoff_recovery_select, busoff_hold_clear, bus_idle} = '0;
      {rx_msg_done, rx_fifo_pending, rx_overrun, busoff_entry} = '0;
      {clr_wake, clr_status_change, clr_overrun, clr_receive_full} = '0;
      {wake_int_enable, status_change_int_enable, dom_req} = '0;
      {overrun_int_enable, receive_full_int_enable} = '0;
      {tx_sent, clr_tx_empty, tx_empty_int_enables} = '0;
      {err_tx_state, err_rx_state} = '0;
      pe(10);
      rst <= 1'b0;
      ne();
      chk("mode", 3'(ciw_off), 3'(mode_state));
      chk("clk_run", 0, module_clk_run);
      chk("tx_flags", 3'h7, tx_buffer_empty_flags);
      chk("txd", 1, bus_transmit_output);
      // Enable, configure, leave init
      pe(1);
      {controller_on_bit, init_request, tx_empty_int_enables} <= 5'h19;
      pe(1);
      ne();
      chk("init_ack", 1, init_ack);
      chk("irq_tx", 1, irq_transmit);
      pe(1);
      init_request <= 1'b0;
      pe(1);
      ne();
      chk("mode", 3'(ciw_run), 3'(mode_state));
      chk("txd", 0, bus_transmit_output);
      chk("clk_run", 1, module_clk_run);
      // Schedule buffer 0, then it empties again
      pe(1);
      clr_tx_empty <= 3'h1;
      pe(1);
      clr_tx_empty <= 3'h0;
      ne();
      chk("tx_flags", 3'h6, tx_buffer_empty_flags);
      chk("irq_tx", 0, irq_transmit);
      pe(1);
      tx_sent <= 3'h1;
      pe(1);
      tx_sent <= 3'h0;
      ne();
      chk("irq_tx", 1, irq_transmit);
      // Receive, masked first
      pe(1);
      rx_msg_done <= 1'b1;
      ne();
      chk("fg_load", 1, rx_fg_load);
      pe(1);
      rx_msg_done <= 1'b0;
      ne();
      chk("rxf", 1, receive_full_flag);
      chk("irq_rx", 0, irq_receive);
      pe(1);
      {receive_full_int_enable, clr_receive_full, rx_msg_done} <= 3'h7;
      pe(1);
      {clr_receive_full, rx_msg_done} <= 2'h0;
      ne();
      chk("rxf", 1, receive_full_flag);
      chk("irq_rx", 1, irq_receive);
      pe(1);
      clr_receive_full <= 1'b1;
      pe(1);
      {clr_receive_full, rx_fifo_pending} <= 2'h1;
      ne();
      chk("irq_rx", 0, irq_receive);
      chk("fg_load", 1, rx_fg_load);
      pe(1);
      rx_fifo_pending <= 1'b0;
      ne();
      chk("rxf", 1, receive_full_flag);
      // Overrun, then a status change
      pe(1);
      {overrun_int_enable, rx_overrun} <= 2'h3;
      pe(1);
      rx_overrun <= 1'b0;
      ne();
      chk("ovr", 1, overrun_flag);
      chk("irq_err", 1, irq_error);
      pe(1);
      clr_overrun <= 1'b1;
      pe(1);
      clr_overrun <= 1'b0;
      ne();
      chk("irq_err", 0, irq_error);
      pe(1);
      {status_change_int_enable, err_tx_state, err_rx_state} <= 5'h16;
      pe(2);
      ne();
      chk("csc", 1, status_change_flag);
      chk("tx_state_field", 3'h1, tx_state_field);
      chk("rx_state_field", 3'h2, rx_state_field);
      chk("irq_err", 1, irq_error);
      // Sleep with wake and filter on; a glitch must not wake
      pe(1);
      {wake_on_activity_enable, wake_int_enable} <= 2'h3;
      {wake_glitch_filter_select, sleep_request, bus_idle} <= 3'h7;
      for (n = 0; n < 20 && sleep_ack !== 1'b1; n++) ne();
      lim(n, 20);
      pe(1);
      {bus_idle, dom_req} <= 2'h1;
      pe(1);
      dom_req <= 1'b0;
      pe(10);
      ne();
      chk("mode", 3'(ciw_sleep), 3'(mode_state));
      pe(1);
      dom_req <= 1'b1;
      for (n = 0; n < 30 && wake_int_flag !== 1'b1; n++) ne();
      lim(n, 30);
      chk("mode", 3'(ciw_run), 3'(mode_state));
      chk("irq_wake", 1, irq_wake);
      chk("synced", 0, bus_synced);
      chk("txd", 1, bus_transmit_output);
      pe(1);
      {sleep_request, dom_req} <= 2'h0;
      pe(20);
      ne();
      chk("synced", 0, bus_synced);
      for (n = 0; n < 100 && bus_synced !== 1'b1; n++) ne();
      lim(n, 100);
      pe(1);
      clr_wake <= 1'b1;
      pe(1);
      clr_wake <= 1'b0;
      ne();
      chk("irq_wake", 0, irq_wake);
      // Sleep without wake: bus activity is masked
      pe(1);
      {wake_on_activity_enable, sleep_request, bus_idle} <= 3'h3;
      for (n = 0; n < 20 && sleep_ack !== 1'b1; n++) ne();
      lim(n, 20);
      pe(1);
      {bus_idle, dom_req} <= 2'h1;
      pe(10);
      ne();
      chk("rx_int", 1, rx_internal);
      chk("mode", 3'(ciw_sleep), 3'(mode_state));
      pe(1);
      {dom_req, init_request} <= 2'h1;
      pe(2);
      ne();
      chk("init_ack", 1, init_ack);
      pe(1);
      {init_request, sleep_request} <= 2'h0;
      pe(2);
      ne();
      chk("mode", 3'(ciw_run), 3'(mode_state));
      // Bus-off on user request: held past the 128 runs
      pe(1);
      {busoff_recovery_select, busoff_entry} <= 2'h3;
      pe(1);
      busoff_entry <= 1'b0;
      ne();
      chk("bo_hold", 1, busoff_hold);
      pe(6000);
      ne();
      chk("busoff", 1, busoff_state);
      pe(1);
      busoff_hold_clear <= 1'b1;
      pe(1);
      busoff_hold_clear <= 1'b0;
      for (n = 0; n < 5 && busoff_state !== 1'b0; n++) ne();
      lim(n, 5);
      // Automatic recovery: not before 128 runs of 11
      pe(1);
      {busoff_recovery_select, busoff_entry} <= 2'h1;
      pe(1);
      // Sleep a while: idle runs seen asleep must not count
      {busoff_entry, sleep_request, bus_idle} <= 3'h3;
      pe(3);
      ne();
      chk("mode", 3'(ciw_sleep), 3'(mode_state));
      chk("clk_run", 0, module_clk_run);
      pe(3000);
      {sleep_request, bus_idle} <= 2'h0;
      pe(3000);
      ne();
      chk("busoff", 1, busoff_state);
      for (n = 0; n < 3500 && busoff_state !== 1'b0; n++) ne();
      lim(n, 3500);
      chk("busoff", 0, busoff_state);
      stop_test();
   end
endmodule
